// >>> hdl/vtal_map.vh
// register map, field positions and opcodes of the vector alu block
`ifndef VTAL_MAP_VH
`define VTAL_MAP_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define VTAL_A_CTRL  8'h00
`define VTAL_A_GO    8'h04
`define VTAL_A_S0L   8'h08
`define VTAL_A_S0H   8'h0C
`define VTAL_A_S1L   8'h10
`define VTAL_A_S1H   8'h14
`define VTAL_A_S2L   8'h18
`define VTAL_A_S2H   8'h1C
`define VTAL_A_DL    8'h20
`define VTAL_A_DH    8'h24
`define VTAL_A_STAT  8'h28
// ----------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------
`define VTAL_F_OPC    9:0
`define VTAL_F_HSEL   10
`define VTAL_F_ATTR   11
`define VTAL_F_STRICT 12
`define VTAL_F_CLAMP  13
`define VTAL_F_MISC   14
`define VTAL_F_EXEC   15
`define VTAL_F_LANE   21:16
`define VTAL_F_MIDX   27:22
`define VTAL_CTRL_RST 32'h0000_8000
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define VTAL_S_DONE 0
`define VTAL_S_INV  1
`define VTAL_S_DEN  2
`define VTAL_S_DZ   3
`define VTAL_S_HIT  4
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define VTAL_OP_MADF16 10'h203
`define VTAL_OP_MADU16 10'h204
`define VTAL_OP_MADI16 10'h205
`define VTAL_OP_FMAF16 10'h206
`define VTAL_OP_FIXUP  10'h207
`define VTAL_OP_IP1LL  10'h274
`define VTAL_OP_IP1LV  10'h275
`define VTAL_OP_IP2LG  10'h276
`define VTAL_OP_IP2    10'h277
`define VTAL_OP_ADDD   10'h280
`define VTAL_OP_MULD   10'h281
`define VTAL_OP_MIND   10'h282
`define VTAL_OP_MAXD   10'h283
`define VTAL_OP_LDXD   10'h284
`define VTAL_OP_MULLO  10'h285
`define VTAL_OP_MULHU  10'h286
`define VTAL_OP_MULHI  10'h287
`define VTAL_OP_LDXS   10'h288
`define VTAL_OP_RDLN   10'h289
`define VTAL_OP_WRLN   10'h28A
`define VTAL_OP_BCNT   10'h28B
`define VTAL_OP_MBLO   10'h28C
`define VTAL_OP_MBHI   10'h28D
`define VTAL_OP_SHL    10'h28F
`define VTAL_OP_SHR    10'h290
`define VTAL_OP_ASR    10'h291
// ----------------------------------------------------------------
// numeric constants
// ----------------------------------------------------------------
`define VTAL_QNAN16 16'hFE00
`define VTAL_ONE16  16'h3C00
`define VTAL_QNAN64 64'h7FF8_0000_0000_0000
`endif

// >>> hdl/vtal_alu.v
// three-operand vector alu lane with an apb register front end
//
// Added by the designer: the register offsets and the APB register port.
`include "vtal_map.vh"
`default_nettype none
module vtal_alu (
    input  wire        clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        result_valid
);
// ----------------------------------------------------------------
// float helpers (flushed denormals, truncating)
// ----------------------------------------------------------------
// class tests on a double
function nan64;
    input [63:0] a;
    nan64 = (a[62:52] == 11'h7FF) && (a[51:0] != 52'h0);
endfunction
function inf64;
    input [63:0] a;
    inf64 = (a[62:0] == {11'h7FF, 52'h0});
endfunction
function zer64;
    input [63:0] a;
    zer64 = (a[62:52] == 11'h000);
endfunction
// widen half to double, denormal becomes zero
function [63:0] f16to64;
    input [15:0] h;
    begin
        if (h[14:10] == 5'h00)
            f16to64 = {h[15], 63'h0};
        else if (h[14:10] == 5'h1F)
            f16to64 = {h[15], 11'h7FF, h[9:0], 42'h0};
        else
            f16to64 = {h[15], ({6'h00, h[14:10]} + 11'h3F0),
                       h[9:0], 42'h0};
    end
endfunction
// widen single to double
function [63:0] f32to64;
    input [31:0] f;
    begin
        if (f[30:23] == 8'h00)
            f32to64 = {f[31], 63'h0};
        else if (f[30:23] == 8'hFF)
            f32to64 = {f[31], 11'h7FF, f[22:0], 29'h0};
        else
            f32to64 = {f[31], ({3'h0, f[30:23]} + 11'h380),
                       f[22:0], 29'h0};
    end
endfunction
// narrow double to half, overflow saturates to inf
function [15:0] f64to16;
    input [63:0] d;
    integer e;
    begin
        e = d[62:52];
        e = e - 1008;
        if (nan64(d))
            f64to16 = {d[63], 6'h3F, d[50:42]};
        else if (e >= 31)
            f64to16 = {d[63], 15'h7C00};
        else if (e <= 0)
            f64to16 = {d[63], 15'h0000};
        else
            f64to16 = {d[63], e[4:0], d[51:42]};
    end
endfunction
// narrow double to single
function [31:0] f64to32;
    input [63:0] d;
    integer e;
    begin
        e = d[62:52];
        e = e - 896;
        if (nan64(d))
            f64to32 = {d[63], 9'h1FF, d[50:29]};
        else if (e >= 255)
            f64to32 = {d[63], 8'hFF, 23'h0};
        else if (e <= 0)
            f64to32 = {d[63], 31'h0};
        else
            f64to32 = {d[63], e[7:0], d[51:29]};
    end
endfunction
// pack sign, exponent, mantissa with range limits
function [63:0] fpack;
    input        s;
    input integer e;
    input [51:0] m;
    begin
        if (e >= 2047)
            fpack = {s, 11'h7FF, 52'h0};
        else if (e <= 0)
            fpack = {s, 63'h0};
        else
            fpack = {s, e[10:0], m};
    end
endfunction
// double multiply
function [63:0] fmul;
    input [63:0] a;
    input [63:0] b;
    reg   [105:0] p;
    reg           s;
    integer       e;
    begin
        s = a[63] ^ b[63];
        p = {1'b1, a[51:0]} * {1'b1, b[51:0]};
        e = a[62:52];
        e = e + b[62:52] - 1023;
        if (nan64(a) || nan64(b))
            fmul = `VTAL_QNAN64;
        else if (inf64(a) || inf64(b))
            fmul = (zer64(a) || zer64(b)) ? `VTAL_QNAN64
                                           : {s, 11'h7FF, 52'h0};
        else if (zer64(a) || zer64(b))
            fmul = {s, 63'h0};
        else if (p[105])
            fmul = fpack(s, e + 1, p[104:53]);
        else
            fmul = fpack(s, e, p[103:52]);
    end
endfunction
// double add, shared by every float sum in the block
function [63:0] fadd;
    input [63:0] a;
    input [63:0] b;
    reg   [63:0] x;
    reg   [63:0] y;
    reg   [56:0] mx;
    reg   [56:0] my;
    reg   [56:0] sm;
    integer      d;
    integer      k;
    integer      i;
    integer      e;
    begin
        if (a[62:0] < b[62:0]) begin
            x = b;
            y = a;
        end else begin
            x = a;
            y = b;
        end
        d = x[62:52];
        d = d - y[62:52];
        mx = {2'b01, x[51:0], 3'h0};
        my = {2'b01, y[51:0], 3'h0} >> d;
        sm = (x[63] ^ y[63]) ? (mx - my) : (mx + my);
        k = 0;
        for (i = 0; i < 57; i = i + 1)
            if (sm[i])
                k = i;
        e = x[62:52];
        e = e + k - 55;
        sm = sm << (56 - k);
        if (nan64(a) || nan64(b))
            fadd = `VTAL_QNAN64;
        else if (inf64(a) && inf64(b) && (a[63] ^ b[63]))
            fadd = `VTAL_QNAN64;
        else if (inf64(x) || zer64(y))
            fadd = x;
        else if (sm == 57'h0)
            fadd = 64'h0;
        else
            fadd = fpack(x[63], e, sm[55:4]);
    end
endfunction
// scale a double by two to the n
function [63:0] fldx;
    input [63:0]        a;
    input signed [31:0] n;
    integer             e;
    begin
        e = a[62:52];
        e = e + n;
        if (zer64(a) || a[62:52] == 11'h7FF)
            fldx = a;
        else
            fldx = fpack(a[63], e, a[51:0]);
    end
endfunction
// ordered less-than for non-nan doubles
function flt;
    input [63:0] a;
    input [63:0] b;
    begin
        if (zer64(a) && zer64(b))
            flt = 1'b0;
        else if (a[63] != b[63])
            flt = a[63];
        else if (a[63])
            flt = a[62:0] > b[62:0];
        else
            flt = a[62:0] < b[62:0];
    end
endfunction
// count of set bits
function [31:0] pop32;
    input [31:0] v;
    integer      i;
    begin
        pop32 = 32'h0;
        for (i = 0; i < 32; i = i + 1)
            pop32 = pop32 + {31'h0, v[i]};
    end
endfunction
// ----------------------------------------------------------------
// registers and apb decode
// ----------------------------------------------------------------
reg  [31:0] ctrl_ff;             // opcode and modifiers
reg  [63:0] s0_ff;               // source 0
reg  [63:0] s1_ff;               // source 1
reg  [63:0] s2_ff;               // source 2
reg  [63:0] dst_ff;              // destination vector register
reg  [4:0]  stat_ff;             // done, sticky flags and lane hit
reg  [31:0] rd_ff;               // read data captured in setup
reg         done_ff;             // one-cycle result pulse
wire        acc  = psel & penable;
wire        wr   = acc & pwrite;
wire        hit_a;               // address maps to a register
wire        go   = wr & (paddr == `VTAL_A_GO);
assign hit_a = (paddr[1:0] == 2'b00) && (paddr <= `VTAL_A_STAT);
assign pready       = 1'b1;      // no wait states
assign pslverr      = acc & ~hit_a;
assign prdata       = rd_ff;
assign result_valid = done_ff;
// ----------------------------------------------------------------
// operand fields
// ----------------------------------------------------------------
wire [9:0]  opc   = ctrl_ff[`VTAL_F_OPC];
wire        hsel  = ctrl_ff[`VTAL_F_HSEL];
wire        attr  = ctrl_ff[`VTAL_F_ATTR];
wire        strict = ctrl_ff[`VTAL_F_STRICT];
wire        clamp = ctrl_ff[`VTAL_F_CLAMP];
wire [5:0]  lane  = ctrl_ff[`VTAL_F_LANE];
// lane chosen by source 1 or the misc index field of the control register
wire [5:0]  lsel  = ctrl_ff[`VTAL_F_MISC] ? ctrl_ff[`VTAL_F_MIDX]
                                          : s1_ff[5:0];
wire        lhit  = (lsel == lane);
// attribute words sit in sources 0 and 2, barycentric in source 1
wire [15:0] p10   = attr ? s0_ff[31:16] : s0_ff[15:0];
wire [15:0] p0    = attr ? s2_ff[31:16] : s2_ff[15:0];
wire [63:0] bary  = f32to64(s1_ff[31:0]);
wire [63:0] itp   = fmul(f16to64(p10), bary);
// ----------------------------------------------------------------
// result selection
// ----------------------------------------------------------------
reg  [63:0] r;                   // raw result
reg  [1:0]  kind;                // 0 wide, 1 word, 2 half sel, 3 low
reg         wen;                 // destination is updated
reg         lane_op;             // ignores the execution mask
reg         fi;                  // invalid
reg         fd;                  // denormal input
reg         fz;                  // divide by zero
reg  [32:0] ui;                  // 16-bit integer mul-add sum
reg  signed [32:0] si;
reg  [63:0] msk;                 // lanes below this one
reg  [15:0] q16;
reg  [15:0] d16;
reg  [15:0] n16;
reg         nn;
reg         nd;
// compute one operation picked by the opcode
always @* begin
    r = 64'h0;
    kind = 2'd0;
    wen = 1'b1;
    lane_op = 1'b0;
    fi = 1'b0;
    fd = 1'b0;
    fz = 1'b0;
    ui = {17'h0, s0_ff[15:0]} * {17'h0, s1_ff[15:0]}
       + {17'h0, s2_ff[15:0]};
    si = $signed(s0_ff[15:0]) * $signed(s1_ff[15:0])
       + $signed(s2_ff[15:0]);
    msk = (64'h1 << lane) - 64'h1;
    q16 = s0_ff[15:0];
    d16 = s1_ff[15:0];
    n16 = s2_ff[15:0];
    nn = (n16[14:10] == 5'h1F) && (n16[9:0] != 10'h0);
    nd = (d16[14:10] == 5'h1F) && (d16[9:0] != 10'h0);
    case (opc)
        `VTAL_OP_MADF16, `VTAL_OP_FMAF16: begin
            kind = 2'd2;
            r[15:0] = f64to16(fadd(fmul(f16to64(s0_ff[15:0]),
                f16to64(s1_ff[15:0])), f16to64(s2_ff[15:0])));
            // clamp to [0,1] when asked
            if (clamp && r[15])
                r[15:0] = 16'h0000;
            else if (clamp && r[14:0] > `VTAL_ONE16)
                r[15:0] = `VTAL_ONE16;
            fi = (r[14:10] == 5'h1F) && (r[9:0] != 10'h0);
        end
        `VTAL_OP_MADU16: begin
            kind = 2'd2;
            r[15:0] = (clamp && ui > 33'h0FFFF) ? 16'hFFFF
                                               : ui[15:0];
        end
        `VTAL_OP_MADI16: begin
            kind = 2'd2;
            if (clamp && si > 33'sh07FFF)
                r[15:0] = 16'h7FFF;
            else if (clamp && si < -33'sh08000)
                r[15:0] = 16'h8000;
            else
                r[15:0] = si[15:0];
        end
        `VTAL_OP_FIXUP: begin
            kind = 2'd2;
            fd = ((d16[14:10] == 5'h00) && (d16[9:0] != 10'h0))
               || ((n16[14:10] == 5'h00) && (n16[9:0] != 10'h0));
            fi = (nn && !n16[9]) || (nd && !d16[9]);
            if (nn)
                r[15:0] = n16 | 16'h0200;
            else if (nd)
                r[15:0] = d16 | 16'h0200;
            else if (d16[14:0] == 15'h0 && n16[14:0] == 15'h0) begin
                r[15:0] = `VTAL_QNAN16;
                fi = 1'b1;
            end else if (d16[14:0] == 15'h7C00
                      && n16[14:0] == 15'h7C00) begin
                r[15:0] = `VTAL_QNAN16;
                fi = 1'b1;
            end else if (d16[14:0] == 15'h0
                      || n16[14:0] == 15'h7C00) begin
                r[15:0] = {d16[15] ^ n16[15], 15'h7C00};
                fz = (d16[14:0] == 15'h0);
            end else if (d16[14:0] == 15'h7C00 || n16[14:0] == 15'h0)
                r[15:0] = {d16[15] ^ n16[15], 15'h0};
            else
                r[15:0] = {d16[15] ^ n16[15], q16[14:0]};
        end
        `VTAL_OP_IP1LL, `VTAL_OP_IP1LV: begin
            kind = 2'd1;
            r[31:0] = f64to32(fadd(itp, f16to64(p0)));
        end
        `VTAL_OP_IP2LG: begin
            kind = 2'd3;
            r[15:0] = f64to16(fadd(itp, f32to64(s2_ff[31:0])));
        end
        `VTAL_OP_IP2: begin
            kind = 2'd2;
            r[15:0] = f64to16(fadd(itp, f32to64(s2_ff[31:0])));
        end
        `VTAL_OP_ADDD:
            r = fadd(s0_ff, s1_ff);
        `VTAL_OP_MULD:
            r = fmul(s0_ff, s1_ff);
        `VTAL_OP_MIND, `VTAL_OP_MAXD: begin
            // nan and signed-zero precedence
            if (strict && nan64(s0_ff) && !s0_ff[51]) begin
                r = s0_ff | 64'h0008_0000_0000_0000;
                fi = 1'b1;
            end else if (strict && nan64(s1_ff) && !s1_ff[51]) begin
                r = s1_ff | 64'h0008_0000_0000_0000;
                fi = 1'b1;
            end else if (nan64(s0_ff))
                r = s1_ff;
            else if (nan64(s1_ff))
                r = s0_ff;
            else if (zer64(s0_ff) && zer64(s1_ff)
                     && (s0_ff[63] ^ s1_ff[63]))
                r = s0_ff[63] ? s0_ff : s1_ff;
            else if (opc == `VTAL_OP_MIND)
                r = flt(s0_ff, s1_ff) ? s0_ff : s1_ff;
            else if (strict)
                r = !flt(s0_ff, s1_ff) ? s0_ff : s1_ff;
            else
                r = flt(s1_ff, s0_ff) ? s0_ff : s1_ff;
        end
        `VTAL_OP_LDXD:
            r = fldx(s0_ff, s1_ff[31:0]);
        `VTAL_OP_LDXS: begin
            kind = 2'd1;
            r[31:0] = f64to32(fldx(f32to64(s0_ff[31:0]),
                                   s1_ff[31:0]));
        end
        `VTAL_OP_MULLO: begin
            kind = 2'd1;
            r = s0_ff[31:0] * s1_ff[31:0];
        end
        `VTAL_OP_MULHU: begin
            kind = 2'd1;
            r = s0_ff[31:0] * s1_ff[31:0];
            r[31:0] = r[63:32];
        end
        `VTAL_OP_MULHI: begin
            kind = 2'd1;
            r = $signed(s0_ff[31:0]) * $signed(s1_ff[31:0]);
            r[31:0] = r[63:32];
        end
        `VTAL_OP_RDLN, `VTAL_OP_WRLN: begin
            // only the selected lane takes the value
            kind = 2'd1;
            lane_op = 1'b1;
            wen = lhit;
            r[31:0] = s0_ff[31:0];
        end
        `VTAL_OP_BCNT: begin
            kind = 2'd1;
            r[31:0] = pop32(s0_ff[31:0]);
        end
        `VTAL_OP_MBLO: begin
            kind = 2'd1;
            r[31:0] = s1_ff[31:0]
                    + pop32(s0_ff[31:0] & msk[31:0]);
        end
        `VTAL_OP_MBHI: begin
            kind = 2'd1;
            r[31:0] = s1_ff[31:0]
                    + pop32(s0_ff[31:0] & msk[63:32]);
        end
        `VTAL_OP_SHL:
            r = s1_ff << s0_ff[5:0];
        `VTAL_OP_SHR:
            r = s1_ff >> s0_ff[5:0];
        `VTAL_OP_ASR:
            r = $signed(s1_ff) >>> s0_ff[5:0];
        default:
            wen = 1'b0;                   // unknown opcode writes nothing
    endcase
end
// ----------------------------------------------------------------
// destination merge
// ----------------------------------------------------------------
reg  [63:0] nxt_dst;
// half results keep the other half of the register
always @* begin
    case (kind)
        2'd0:    nxt_dst = r;
        2'd1:    nxt_dst = {dst_ff[63:32], r[31:0]};
        2'd2:    nxt_dst = hsel ? {dst_ff[63:32], r[15:0], dst_ff[15:0]}
                                : {dst_ff[63:16], r[15:0]};
        default: nxt_dst = {dst_ff[63:16], r[15:0]};
    endcase
end
// masked lanes keep their value; lane moves ignore the mask
wire do_wr = go & wen & (lane_op | ctrl_ff[`VTAL_F_EXEC]);
// ----------------------------------------------------------------
// register writes, execution and flags
// ----------------------------------------------------------------
// writes land at the access edge; flag set wins over a clear
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ctrl_ff <= `VTAL_CTRL_RST;
        s0_ff   <= 64'h0;
        s1_ff   <= 64'h0;
        s2_ff   <= 64'h0;
        dst_ff  <= 64'h0;
        stat_ff <= 5'h00;
        done_ff <= 1'b0;
    end else begin
        done_ff <= go;
        if (wr) begin
            case (paddr)
                `VTAL_A_CTRL: ctrl_ff        <= pwdata;
                `VTAL_A_S0L:  s0_ff[31:0]    <= pwdata;
                `VTAL_A_S0H:  s0_ff[63:32]   <= pwdata;
                `VTAL_A_S1L:  s1_ff[31:0]    <= pwdata;
                `VTAL_A_S1H:  s1_ff[63:32]   <= pwdata;
                `VTAL_A_S2L:  s2_ff[31:0]    <= pwdata;
                `VTAL_A_S2H:  s2_ff[63:32]   <= pwdata;
                `VTAL_A_DL:   dst_ff[31:0]   <= pwdata;
                `VTAL_A_DH:   dst_ff[63:32]  <= pwdata;
                `VTAL_A_STAT: stat_ff        <= stat_ff & ~pwdata[4:0];
                default:      ;
            endcase
        end
        if (do_wr)
            dst_ff <= nxt_dst;
        if (go) begin
            stat_ff[`VTAL_S_DONE] <= 1'b1;
            stat_ff[`VTAL_S_HIT]  <= lhit;
            if (fi)
                stat_ff[`VTAL_S_INV] <= 1'b1;
            if (fd)
                stat_ff[`VTAL_S_DEN] <= 1'b1;
            if (fz)
                stat_ff[`VTAL_S_DZ]  <= 1'b1;
        end
    end
end
// ----------------------------------------------------------------
// read data, captured in the setup cycle
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rd_ff <= 32'h0;
    end else if (psel && !penable) begin
        case (paddr)
            `VTAL_A_CTRL: rd_ff <= ctrl_ff;
            `VTAL_A_S0L:  rd_ff <= s0_ff[31:0];
            `VTAL_A_S0H:  rd_ff <= s0_ff[63:32];
            `VTAL_A_S1L:  rd_ff <= s1_ff[31:0];
            `VTAL_A_S1H:  rd_ff <= s1_ff[63:32];
            `VTAL_A_S2L:  rd_ff <= s2_ff[31:0];
            `VTAL_A_S2H:  rd_ff <= s2_ff[63:32];
            `VTAL_A_DL:   rd_ff <= dst_ff[31:0];
            `VTAL_A_DH:   rd_ff <= dst_ff[63:32];
            `VTAL_A_STAT: rd_ff <= {27'h0, stat_ff};
            default:      rd_ff <= 32'h0;  // go and unmapped read zero
        endcase
    end
end
endmodule // vtal_alu
`default_nettype wire

// >>> testbench/vtal_alu_checker.sv
// port-level assertions for the vector alu register front end
`default_nettype none
module vtal_alu_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    sequence s_acc; psel && penable; endsequence
    sequence s_go; psel && penable && pwrite && paddr == 8'h04; endsequence
    sequence s_gord; psel && !penable && !pwrite && paddr == 8'h04;
    endsequence
    a_zero_wait: assert property (s_acc |-> pready)
        else $error("access without ready");
    a_go_pulse: assert property (s_go |=> result_valid)
        else $error("go gave no result pulse");
    a_pulse_cause: assert property (result_valid |-> $past(pwrite
        && psel && penable && paddr == 8'h04)) else $error("stray pulse");
    a_pulse_one: assert property (result_valid |=> !result_valid)
        else $error("result pulse too long");
    a_err_phase: assert property (pslverr |-> s_acc)
        else $error("error outside access");
    a_err_bad: assert property (psel && penable && (paddr > 8'h28
        || paddr[1:0] != 2'h0) |-> pslverr) else $error("unmapped no error");
    a_err_good: assert property (psel && penable && paddr <= 8'h28
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped error");
    a_go_zero: assert property (s_gord ##1 s_acc |-> prdata == 32'h0)
        else $error("go read not zero");
endmodule // vtal_alu_checker
bind vtal_alu vtal_alu_checker u_chk (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .result_valid);
`default_nettype wire

// >>> testbench/vtal_apb_master.sv
// apb master standing in for the issue logic
`default_nettype none
module vtal_apb_master (
    input  wire logic        clk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    // one transfer; released lines flip so stale values never match
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
    endtask
endmodule // vtal_apb_master
`default_nettype wire

// >>> testbench/vtal_alu_test.sv
// self-checking bench for the vector alu
`include "vtal_map.vh"
`default_nettype none
module vtal_alu_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] EX = 32'h8000;    // exec mask on
    localparam logic [63:0] D0 = 64'h11112222; // old destination
    localparam logic [63:0] ONE = 64'h3FF0000000000000;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    wire logic psel, penable, pwrite, pready, pslverr, result_valid;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int failures, n_tests;
    logic [31:0] q;
    logic e;
    vtal_apb_master m (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    vtal_alu dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .result_valid);
    initial forever #4 clk = ~clk;
    task chk(input logic [63:0] g, x);
        n_tests++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask
    // load sources and old destination, issue, read the result back
    task run(input logic [31:0] c, input logic [63:0] a, b, s, x);
        logic [255:0] v;
        logic [31:0] h;
        v = {D0, s, b, a};
        for (int i = 0; i < 8; i++)
            m.xfer(1'h1, 8'(8 + 4 * i), v[32 * i +: 32], q, e);
        m.xfer(1'h1, `VTAL_A_CTRL, c, q, e);
        m.xfer(1'h1, `VTAL_A_GO, 32'h0, q, e);
        m.xfer(1'h0, `VTAL_A_DL, 32'h0, q, e);
        m.xfer(1'h0, `VTAL_A_DH, 32'h0, h, e);
        chk({h, q}, x);
        $display("test %h done", c[9:0]);
    endtask
    task end_sim;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        m.xfer(1'h0, `VTAL_A_CTRL, 32'h0, q, e);
        chk(q, `VTAL_CTRL_RST);
        run(EX | `VTAL_OP_MADU16, 3, 4, 5, 64'h11110011);
        run(EX | 32'h2400 | `VTAL_OP_MADU16, 16'hFFFF, 2, 0, 64'hFFFF2222);
        run(EX | `VTAL_OP_MADI16, 16'hFFFE, 3, 1, 64'h1111FFFB);
        run(EX | `VTAL_OP_FIXUP, 0, 16'h3C00, 16'h7C01, 64'h11117E01);
        run(EX | `VTAL_OP_FIXUP, 0, 0, 0, 64'h1111FE00);
        m.xfer(1'h0, `VTAL_A_STAT, 32'h0, q, e);
        chk(q[1:0], 2'h3);
        run(EX | `VTAL_OP_FIXUP, 16'h3C00, 16'hBC00, 16'h4000, 64'h1111BC00);
        run(EX | `VTAL_OP_FIXUP, 0, 0, 16'h4000, 64'h11117C00);
        run(EX | `VTAL_OP_FIXUP, 16'h3C00, 16'h8001, 16'h4000,
            64'h1111BC00);
        m.xfer(1'h0, `VTAL_A_STAT, 32'h0, q, e);
        chk(q[3:0], 4'hF);
        m.xfer(1'h1, `VTAL_A_STAT, 32'h1F, q, e);
        m.xfer(1'h0, `VTAL_A_STAT, 32'h0, q, e);
        chk(q, 0);
        run(EX | `VTAL_OP_ADDD, ONE, ONE, 0, 64'h4000000000000000);
        run(EX | `VTAL_OP_MULD, ONE, ONE, 0, ONE);
        run(EX | `VTAL_OP_MIND, 0, {1'h1, 63'h0}, 0, {1'h1, 63'h0});
        run(EX | `VTAL_OP_MIND, `VTAL_QNAN64, ONE, 0, ONE);
        run(EX | 32'h1000 | `VTAL_OP_MAXD, ONE, 64'h7FF0000000000001, 0,
            64'h7FF8000000000001);
        run(EX | `VTAL_OP_LDXD, ONE, 3, 0, 64'h4020000000000000);
        run(EX | `VTAL_OP_LDXS, 32'h3F800000, 32'hFFFFFFFF, 0, 32'h3F000000);
        run(EX | `VTAL_OP_MULLO, 32'hFFFFFFFF, 2, 0, 32'hFFFFFFFE);
        run(EX | `VTAL_OP_MULHU, 32'hFFFFFFFF, 2, 0, 1);
        run(EX | `VTAL_OP_MULHI, 32'hFFFFFFFF, 2, 0, 32'hFFFFFFFF);
        run(EX | `VTAL_OP_BCNT, 32'hF0F00001, 0, 0, 9);
        run(EX | 32'h80000 | `VTAL_OP_MBLO, 16'hFFFF, 5, 0, 13);
        run(EX | 32'h280000 | `VTAL_OP_MBHI, 8'hFF, 0, 0, 8);
        run(EX | `VTAL_OP_SHL, 8'h44, 64'h80000000000000F0, 0, 12'hF00);
        run(EX | `VTAL_OP_SHR, 8'h44, 64'h80000000000000F0, 0,
            64'h080000000000000F);
        run(EX | `VTAL_OP_ASR, 8'h44, 64'h80000000000000F0, 0,
            64'hF80000000000000F);
        run(32'h30000 | `VTAL_OP_RDLN, 32'h12345678, 3, 0, 32'h12345678);
        run(EX | 32'h30000 | `VTAL_OP_WRLN, 7, 4, 0, D0);
        run(32'hC34000 | `VTAL_OP_WRLN, 7, 9, 0, 7);
        run(EX | 32'h3FF, 7, 7, 7, D0);
        run(EX | 32'h800 | `VTAL_OP_IP1LL, 32'h40000000, 32'h3F000000,
            32'h3C000000, 32'h40000000);
        run(EX | `VTAL_OP_IP1LV, 16'h4000, 32'h3F000000, 16'h3C00,
            32'h40000000);
        run(EX | 32'h400 | `VTAL_OP_IP2LG, 16'h4000, 32'h3F000000,
            32'h3F800000, 64'h11114000);
        run(EX | 32'h400 | `VTAL_OP_IP2, 16'h4000, 32'h3F000000,
            32'h3F800000, 64'h40002222);
        run(EX | `VTAL_OP_FMAF16, 16'h3C00, 16'h4000, 16'h3C00,
            64'h11114200);
        run(EX | 32'h2400 | `VTAL_OP_MADF16, 16'h3C00, 16'h4000, 16'h3C00,
            64'h3C002222);
        m.xfer(1'h0, `VTAL_A_GO, 32'h0, q, e);
        chk({e, q}, 33'h0);
        m.xfer(1'h0, 8'h2C, 32'h0, q, e);
        chk({e, q}, 33'h100000000);
        end_sim;
    end
endmodule // vtal_alu_test
`default_nettype wire
